/* File: common/eic_pkg.sv */
`default_nettype none
package eic_pkg;
  // host control word bit positions
  localparam int CTRL_OUT_EN_LSB   = 0;
  localparam int CTRL_OUT_HI_LSB   = 4;
  localparam int CTRL_STB_RST_LSB  = 20;
  localparam int CTRL_HOME_CMD     = 24;
  localparam int CTRL_PRELOAD_RST  = 25;
  localparam int CTRL_PRELOAD_CMD  = 26;
  localparam int CTRL_CLEAR_ERR    = 31;
  // synchronised pin vector layout
  localparam int PIN_ENC_LSB       = 0;
  localparam int PIN_QUAD_A        = 16;
  localparam int PIN_QUAD_B        = 17;
  localparam int PIN_MARKER        = 18;
  localparam int PIN_PRELOAD       = 19;
  localparam int PIN_STB_LSB       = 20;
  localparam int PIN_W             = 24;
  // comparators
  localparam int NUM_CMP           = 32;
  localparam int UPPER_CMP_LSB     = 16;
  localparam int GATE_CMP_BASE     = 4;  // comparator 5, zero based
  // reset values
  localparam logic [31:0] TOTAL_RESET   = 32'h0000_0000;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [15:0] TIMER_MAX     = 16'hFFFF;
  localparam logic [15:0] QUAD_ERR_CODE = 16'h0001;
  // timing
  localparam int TIME_MS_NS        = 1000000;
  localparam int CLK_PERIOD_NS     = 10;
  localparam int MS_CYCLES_DEFAULT = TIME_MS_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic        quad_mode;      // 0: absolute_gray_mode
    logic [3:0]  strobe_rising;
    logic [3:0]  strobe_gated;   // comparator gating per strobe
    logic        t1_two_input;
    logic        t2_two_input;
    logic        out58_enabled;
    logic [15:0] home_value;
    logic [15:0] preload_value;
  } eic_cfg_t;

  typedef struct packed {
    logic        we;
    logic [4:0]  index;
    logic [15:0] on_preset;
    logic [15:0] off_preset;
  } eic_preset_wr_t;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] filt;
    logic [PIN_W-1:0] prev;
  } eic_sync_t;

  typedef struct packed {
    logic        running;
    logic [15:0] ms_cnt;
    logic [15:0] result;
  } eic_timer_t;

  typedef struct packed {
    eic_sync_t                      sync;
    logic [15:0]                    gray;
    logic [15:0]                    pos;
    logic [15:0]                    binary;
    logic [31:0]                    total;
    logic [3:0][15:0]               strobe_cap;
    logic [3:0]                     strobe_latch;
    logic                           home_armed;
    logic                           home_found;
    logic                           preload_latch;
    logic                           err_flag;
    logic [15:0]                    err_word;
    logic [31:0]                    ctrl_prev;
    logic [16:0]                    tick_cnt;
    logic [1:0][$bits(eic_timer_t)-1:0] timers;
    logic [NUM_CMP-1:0][15:0]       on_preset;
    logic [NUM_CMP-1:0][15:0]       off_preset;
    logic [15:0]                    upper_status;
    logic [7:0]                     out_en;
    logic [7:0]                     hw_out;
  } eic_state_t;
endpackage
`default_nettype wire

/* File: design/eic_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - report gray-to-binary, or quadrature count
// - total zero at reset, loadable by command
// - quadrature home marker zeroes total count
// - preload input leaves total count alone
// - inputs 9-12 strobe-capture binary data
// - per-strobe rising or falling edge select
// - timer one ms, input 10 or 10-9
// - timer one start needs latch, comparator six
// - timer one stop gated by comparator five
// - timer two on 12, latch, comparator eight
// - timer two stop gated by comparator seven
// - status word of comparators 17 to 32
// - control bits 0-7 enable outputs 1-8
// - disabled outputs 5-8 ignore enable bits
// - bits 20-23 clear strobe latches
// - held reset keeps flag off, captures always
// - bit 24 arms homing, clears found; marker loads value, sets found
// - bit 25 clears preload latch, allows all
// - bit 26 preloads, no latch set
// - bit 31 clears error flag and word
// - bits 24-26 quadrature-only commands; reserved bits ignored
// - total count in words five and six
module eic_top #(
  parameter int MS_CYCLES = eic_pkg::MS_CYCLES_DEFAULT
) (
  input  wire logic                   CLOCK,
  input  wire logic                   RESETN,
  input  wire logic [15:0]            ENC_IN,
  input  wire logic                   QUAD_A,
  input  wire logic                   QUAD_B,
  input  wire logic                   HOME_MARKER,
  input  wire logic                   PRELOAD_SWITCH,
  input  wire logic [3:0]             STROBE_IN,
  input  wire eic_pkg::eic_cfg_t      CFG,
  input  wire eic_pkg::eic_preset_wr_t PRESET_WR,
  input  wire logic [31:0]            HOST_CTRL,
  input  wire logic                   TOTAL_LOAD,
  input  wire logic [31:0]            TOTAL_LOAD_VALUE,
  input  wire logic                   ERROR_EVENT,
  input  wire logic [15:0]            ERROR_CODE,
  output logic [15:0]                 GRAY_VALUE,
  output logic [15:0]                 BINARY_POSITION,
  output logic [15:0]                 TOTAL_WORD5,
  output logic [15:0]                 TOTAL_WORD6,
  output logic [3:0][15:0]            STROBE_CAPTURE,
  output logic [3:0]                  STROBE_FLAG,
  output logic [15:0]                 TIMER1_MS,
  output logic [15:0]                 TIMER2_MS,
  output logic [15:0]                 UPPER_CMP_STATUS,
  output logic [7:0]                  OUT_ENABLE,
  output logic [7:0]                  HW_OUT,
  output logic                        HOME_FOUND,
  output logic                        PRELOAD_LATCH,
  output logic                        ERROR_FLAG,
  output logic [15:0]                 ERROR_STATUS
);

  localparam logic [16:0] TICK_LAST = 17'(MS_CYCLES - 1);

  eic_pkg::eic_state_t st;
  eic_pkg::eic_state_t next_st;

  logic [eic_pkg::PIN_W-1:0]   pins;
  logic [eic_pkg::NUM_CMP-1:0] cmp;
  logic [3:0]                  stb_lvl;
  logic [3:0]                  stb_old;
  logic [3:0]                  e_stb;
  logic                        quad_move;
  logic                        quad_err;
  logic                        quad_up;
  logic                        mark_hit;
  logic                        pre_edge;
  logic                        home_rise;
  logic                        pcmd_rise;
  logic                        clr_rise;
  logic                        tick;
  logic [1:0]                  t_start;
  logic [1:0]                  t_stop;

  function automatic logic [15:0] gray2bin(input logic [15:0] g);
    logic [15:0] b;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  assign pins = {STROBE_IN, PRELOAD_SWITCH, HOME_MARKER, QUAD_B, QUAD_A, ENC_IN};

  ////////////////////////////////////////////////////////////////////////
  // comparators from presets and current binary data
  generate
    for (genvar gi = 0; gi < eic_pkg::NUM_CMP; gi++) begin : g_cmp
      assign cmp[gi] = (st.on_preset[gi] <= st.off_preset[gi]) ?
                       (st.binary >= st.on_preset[gi] && st.binary <= st.off_preset[gi]) :
                       (st.binary >= st.on_preset[gi] || st.binary <= st.off_preset[gi]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // events from filtered pins and host bits
  assign stb_lvl   = st.sync.filt[eic_pkg::PIN_STB_LSB +: 4];
  assign stb_old   = st.sync.prev[eic_pkg::PIN_STB_LSB +: 4];
  assign e_stb     = (CFG.strobe_rising & stb_lvl & ~stb_old) |
                     (~CFG.strobe_rising & ~stb_lvl & stb_old);
  assign quad_move = CFG.quad_mode &&
                     (st.sync.filt[eic_pkg::PIN_QUAD_A] != st.sync.prev[eic_pkg::PIN_QUAD_A]) !=
                     (st.sync.filt[eic_pkg::PIN_QUAD_B] != st.sync.prev[eic_pkg::PIN_QUAD_B]);
  assign quad_err  = CFG.quad_mode &&
                     (st.sync.filt[eic_pkg::PIN_QUAD_A] != st.sync.prev[eic_pkg::PIN_QUAD_A]) &&
                     (st.sync.filt[eic_pkg::PIN_QUAD_B] != st.sync.prev[eic_pkg::PIN_QUAD_B]);
  assign quad_up   = st.sync.prev[eic_pkg::PIN_QUAD_A] ^ st.sync.filt[eic_pkg::PIN_QUAD_B];
  assign mark_hit  = CFG.quad_mode && st.home_armed &&
                     st.sync.filt[eic_pkg::PIN_MARKER] && !st.sync.prev[eic_pkg::PIN_MARKER];
  assign pre_edge  = CFG.quad_mode &&
                     st.sync.filt[eic_pkg::PIN_PRELOAD] && !st.sync.prev[eic_pkg::PIN_PRELOAD];
  assign home_rise = CFG.quad_mode && HOST_CTRL[eic_pkg::CTRL_HOME_CMD] &&
                     !st.ctrl_prev[eic_pkg::CTRL_HOME_CMD];
  assign pcmd_rise = CFG.quad_mode && HOST_CTRL[eic_pkg::CTRL_PRELOAD_CMD] &&
                     !st.ctrl_prev[eic_pkg::CTRL_PRELOAD_CMD];
  assign clr_rise  = HOST_CTRL[eic_pkg::CTRL_CLEAR_ERR] && !st.ctrl_prev[eic_pkg::CTRL_CLEAR_ERR];
  assign tick      = (st.tick_cnt == TICK_LAST);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    eic_pkg::eic_timer_t tm;
    logic [15:0] new_bin;
    logic [15:0] diff;
    int          sidx;
    int          pidx;
    logic        two;
    tm      = '0;
    new_bin = '0;
    diff    = '0;
    sidx    = 0;
    pidx    = 0;
    two     = 1'b0;
    t_start = '0;
    t_stop  = '0;
    next_st = st;

    // three-stage pin filter: accept a bit when stages two and three agree
    next_st.sync.s1   = pins;
    next_st.sync.s2   = st.sync.s1;
    next_st.sync.s3   = st.sync.s2;
    next_st.sync.filt = (st.sync.s3 & ~(st.sync.s2 ^ st.sync.s3)) |
                        (st.sync.filt & (st.sync.s2 ^ st.sync.s3));
    next_st.sync.prev = st.sync.filt;
    next_st.ctrl_prev = HOST_CTRL;

    next_st.gray = st.sync.filt[eic_pkg::PIN_ENC_LSB +: 16];
    new_bin      = gray2bin(st.gray);

    if (PRESET_WR.we) begin
      next_st.on_preset[PRESET_WR.index]  = PRESET_WR.on_preset;
      next_st.off_preset[PRESET_WR.index] = PRESET_WR.off_preset;
    end

    // position counter, quadrature only
    if (mark_hit) begin
      next_st.pos        = CFG.home_value;
      next_st.home_found = 1'b1;
      next_st.home_armed = 1'b0;
    end else if (pcmd_rise) begin
      next_st.pos = CFG.preload_value;
    end else if (pre_edge && (!st.preload_latch || HOST_CTRL[eic_pkg::CTRL_PRELOAD_RST])) begin
      next_st.pos = CFG.preload_value;
    end else if (quad_move) begin
      next_st.pos = quad_up ? st.pos + 16'h0001 : st.pos - 16'h0001;
    end
    if (home_rise) begin
      next_st.home_armed = 1'b1;
      next_st.home_found = 1'b0;
    end

    // preload latch: set by the switch only, held clear by bit 25
    if (pre_edge) begin
      next_st.preload_latch = 1'b1;
    end
    if (CFG.quad_mode && HOST_CTRL[eic_pkg::CTRL_PRELOAD_RST]) begin
      next_st.preload_latch = 1'b0;
    end

    next_st.binary = CFG.quad_mode ? st.pos : new_bin;

    // total count; preload never touches it
    diff = new_bin - st.binary;
    if (TOTAL_LOAD) begin
      next_st.total = TOTAL_LOAD_VALUE;
    end else if (mark_hit) begin
      next_st.total = eic_pkg::TOTAL_RESET;
    end else if (quad_move) begin
      next_st.total = quad_up ? st.total + 32'h0000_0001 : st.total - 32'h0000_0001;
    end else if (!CFG.quad_mode) begin
      next_st.total = st.total + {{16{diff[15]}}, diff};
    end

    // strobes
    for (int k = 0; k < 4; k++) begin
      if (HOST_CTRL[eic_pkg::CTRL_STB_RST_LSB + k]) begin
        next_st.strobe_latch[k] = 1'b0;
        if (e_stb[k]) begin
          next_st.strobe_cap[k] = st.binary;
        end
      end else if (e_stb[k] && !st.strobe_latch[k]) begin
        next_st.strobe_cap[k]   = st.binary;
        next_st.strobe_latch[k] = 1'b1;
      end
    end

    // millisecond interval timers
    next_st.tick_cnt = tick ? 17'h0_0000 : st.tick_cnt + 17'h0_0001;
    for (int t = 0; t < 2; t++) begin
      tm   = st.timers[t];
      two  = (t == 0) ? CFG.t1_two_input : CFG.t2_two_input;
      sidx = 2 * t + 1;
      pidx = two ? 2 * t : sidx;
      t_stop[t]  = tm.running && e_stb[pidx] &&
                   (!two || !CFG.strobe_gated[pidx] || cmp[eic_pkg::GATE_CMP_BASE + pidx]);
      t_start[t] = !tm.running && e_stb[sidx] && !st.strobe_latch[sidx] &&
                   (!CFG.strobe_gated[sidx] || cmp[eic_pkg::GATE_CMP_BASE + sidx]);
      if (t_stop[t]) begin
        tm.result  = tm.ms_cnt;
        tm.running = 1'b0;
      end else if (t_start[t]) begin
        tm.running = 1'b1;
        tm.ms_cnt  = eic_pkg::WORD_RESET;
      end else if (tm.running && tick && tm.ms_cnt != eic_pkg::TIMER_MAX) begin
        tm.ms_cnt = tm.ms_cnt + 16'h0001;
      end
      next_st.timers[t] = tm;
    end

    // error status; a new error wins over a clear in the same cycle
    if (clr_rise) begin
      next_st.err_flag = 1'b0;
      next_st.err_word = eic_pkg::WORD_RESET;
    end
    if ((ERROR_EVENT || quad_err) && !next_st.err_flag) begin
      next_st.err_flag = 1'b1;
      next_st.err_word = ERROR_EVENT ? ERROR_CODE : eic_pkg::QUAD_ERR_CODE;
    end

    next_st.upper_status = cmp[eic_pkg::UPPER_CMP_LSB +: 16];
    next_st.out_en[3:0]  = HOST_CTRL[eic_pkg::CTRL_OUT_EN_LSB +: 4];
    next_st.out_en[7:4]  = CFG.out58_enabled ? HOST_CTRL[eic_pkg::CTRL_OUT_HI_LSB +: 4] : 4'h0;
    next_st.hw_out       = next_st.out_en & cmp[7:0];
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign GRAY_VALUE       = st.gray;
  assign BINARY_POSITION  = st.binary;
  assign TOTAL_WORD5      = st.total[15:0];
  assign TOTAL_WORD6      = st.total[31:16];
  assign STROBE_CAPTURE   = st.strobe_cap;
  assign STROBE_FLAG      = st.strobe_latch;
  assign TIMER1_MS        = st.timers[0][15:0];
  assign TIMER2_MS        = st.timers[1][15:0];
  assign UPPER_CMP_STATUS = st.upper_status;
  assign OUT_ENABLE       = st.out_en;
  assign HW_OUT           = st.hw_out;
  assign HOME_FOUND       = st.home_found;
  assign PRELOAD_LATCH    = st.preload_latch;
  assign ERROR_FLAG       = st.err_flag;
  assign ERROR_STATUS     = st.err_word;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  gray_conv_a: assert property (!CFG.quad_mode |=> BINARY_POSITION == gray2bin($past(st.gray)))
    else $error("binary data is not the gray conversion");
  total_load_a: assert property (TOTAL_LOAD |=> {TOTAL_WORD6, TOTAL_WORD5} == $past(TOTAL_LOAD_VALUE))
    else $error("total count load lost");
  home_zero_a: assert property (mark_hit && !TOTAL_LOAD |=> {TOTAL_WORD6, TOTAL_WORD5} == 32'h0)
    else $error("home marker did not zero total");
  preload_total_a: assert property (pre_edge && !TOTAL_LOAD && !mark_hit && !quad_move
                                    |=> $stable({TOTAL_WORD6, TOTAL_WORD5}))
    else $error("preload input changed total");
  strobe_cap_a: assert property (e_stb[0] && !st.strobe_latch[0] |=> STROBE_CAPTURE[0] == $past(st.binary))
    else $error("strobe one capture missed");
  strobe_hold_a: assert property (HOST_CTRL[20] ##1 HOST_CTRL[20] |=> !STROBE_FLAG[0])
    else $error("strobe flag set while reset held");
  t1_gate_a: assert property (!st.timers[0][32] && e_stb[1] && CFG.strobe_gated[1] && !cmp[5]
                              |=> !st.timers[0][32])
    else $error("timer one started without comparator six");
  t1_result_a: assert property (t_stop[0] |=> TIMER1_MS == $past(st.timers[0][31:16]) && !st.timers[0][32])
    else $error("timer one result not taken at stop");
  out_mask_a: assert property (!CFG.out58_enabled |=> OUT_ENABLE[7:4] == 4'h0)
    else $error("disabled outputs enabled");
  out_enable_a: assert property (1'b1 |=> OUT_ENABLE[3:0] == $past(HOST_CTRL[3:0]))
    else $error("enable bits not followed");
  home_found_a: assert property (mark_hit |=> HOME_FOUND ##1 BINARY_POSITION == $past(CFG.home_value, 2))
    else $error("home not loaded");
  err_clear_a: assert property (clr_rise && !ERROR_EVENT && !quad_err |=> !ERROR_FLAG && ERROR_STATUS == 16'h0)
    else $error("clear error ignored");
  err_rearm_a: assert property (ERROR_FLAG && HOST_CTRL[31] && st.ctrl_prev[31] |=> ERROR_FLAG)
    else $error("held clear bit suppresses errors");

  home_cov: cover property (home_rise ##[1:1000] mark_hit);
  timer_cov: cover property (t_start[0] ##[1:1000] t_stop[0]);
  strobe_cov: cover property (e_stb[3] && !st.strobe_latch[3]);

endmodule  // eic_top
`default_nettype wire

/* File: bench/eic_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// sweep partner: presents the control word to the block once per clock
module eic_host_model (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic [31:0] SWEEP_WORD,
  output var  logic [31:0] HOST_CTRL
);
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      HOST_CTRL <= 32'h0000_0000;
    end else begin
      HOST_CTRL <= SWEEP_WORD;
    end
  end
endmodule // eic_host_model
`default_nettype wire

/* File: bench/tb_encoder_counter_io_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_encoder_counter_io_control;
  logic                   CLOCK = 0;
  logic                   RESETN = 0;
  logic [15:0]            enc = 16'h0000;
  logic                   qa = 0, qb = 0, marker = 0, pswitch = 0, tload = 0, err_ev = 0;
  logic [3:0]             stb = 4'h0;
  eic_pkg::eic_cfg_t      cfg = '0;
  eic_pkg::eic_preset_wr_t pwr = '0;
  logic [31:0]            host_word = 32'h0000_0000, tload_val = 32'h0000_0000, tot;
  logic [15:0]            err_code = 16'h0000, gray, binv, t5, t6, t1ms, t2ms, upper, err_st;
  logic [3:0][15:0]       cap;
  logic [3:0]             sflag;
  logic [7:0]             oen, hw;
  logic [31:0]            hctrl;
  logic                   home_found, pl_latch, err_flag;
  int                     error_cnt = 0, num_checks = 0, cycles = 0;
  always #5 CLOCK = ~CLOCK;
  assign tot = {t6, t5};
  eic_host_model u_host (.CLOCK(CLOCK), .RESETN(RESETN), .SWEEP_WORD(host_word), .HOST_CTRL(hctrl));
  eic_top #(.MS_CYCLES(10)) u_dut (
    .CLOCK(CLOCK), .RESETN(RESETN), .ENC_IN(enc), .QUAD_A(qa), .QUAD_B(qb), .HOME_MARKER(marker),
    .PRELOAD_SWITCH(pswitch), .STROBE_IN(stb), .CFG(cfg), .PRESET_WR(pwr), .HOST_CTRL(hctrl),
    .TOTAL_LOAD(tload), .TOTAL_LOAD_VALUE(tload_val), .ERROR_EVENT(err_ev), .ERROR_CODE(err_code),
    .GRAY_VALUE(gray), .BINARY_POSITION(binv), .TOTAL_WORD5(t5), .TOTAL_WORD6(t6), .STROBE_CAPTURE(cap),
    .STROBE_FLAG(sflag), .TIMER1_MS(t1ms), .TIMER2_MS(t2ms), .UPPER_CMP_STATUS(upper), .OUT_ENABLE(oen),
    .HW_OUT(hw), .HOME_FOUND(home_found), .PRELOAD_LATCH(pl_latch), .ERROR_FLAG(err_flag),
    .ERROR_STATUS(err_st));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wcyc(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic set_enc(input logic [15:0] b);
    enc = b ^ (b >> 1);
    wcyc(8);
  endtask
  task automatic pulse_stb(input int k);
    stb[k] = 1'b1;
    wcyc(8);
    stb[k] = 1'b0;
    wcyc(8);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_abs_total();
    `CHK("total_reset", 32'h0000_0000, tot)
    set_enc(16'h1234);
    `CHK("gray", 16'h1234 ^ 16'h091A, gray)
    `CHK("binary", 16'h1234, binv)
    tload_val = 32'hA5C3_0F01;
    tload = 1'b1;
    wcyc(1);
    tload = 1'b0;
    wcyc(3);
    `CHK("total_word5", 16'h0F01, t5)
    `CHK("total_word6", 16'hA5C3, t6)
    host_word = 32'h0100_0000;
    wcyc(12);
    `CHK("home_abs", 1'b0, home_found)
    host_word = 32'h0000_0000;
    $display("test abs_total done");
  endtask
  task automatic test_outputs();
    host_word = 32'h000F_FFFF;
    wcyc(4);
    `CHK("out_en_off58", 8'h0F, oen)
    cfg.out58_enabled = 1'b1;
    host_word = 32'h0000_00A5;
    wcyc(4);
    `CHK("out_en", 8'hA5, oen)
    pwr = '{we: 1'b1, index: 5'd0, on_preset: 16'h0000, off_preset: 16'hFFFF};
    wcyc(1);
    pwr = '0;
    wcyc(3);
    `CHK("hw_out", 8'h01, hw)
    pwr = '{we: 1'b1, index: 5'd16, on_preset: 16'h0010, off_preset: 16'h0020};
    wcyc(1);
    pwr = '0;
    set_enc(16'h0018);
    `CHK("cmp17_on", 1'b1, upper[0])
    set_enc(16'h0030);
    `CHK("cmp17_off", 1'b0, upper[0])
    host_word = 32'h0000_0000;
    $display("test outputs done");
  endtask
  task automatic test_strobe();
    cfg.strobe_rising = 4'b0011;
    set_enc(16'h0444);
    pulse_stb(0);
    `CHK("cap1", 16'h0444, cap[0])
    `CHK("flag1", 1'b1, sflag[0])
    set_enc(16'h0555);
    pulse_stb(0);
    `CHK("cap1_latched", 16'h0444, cap[0])
    host_word = 32'h0010_0000;
    wcyc(3);
    `CHK("flag1_clr", 1'b0, sflag[0])
    pulse_stb(0);
    `CHK("cap1_held", 16'h0555, cap[0])
    `CHK("flag1_held", 1'b0, sflag[0])
    host_word = 32'h0000_0000;
    stb[2] = 1'b1;
    wcyc(8);
    `CHK("cap3_rise", 16'h0000, cap[2])
    stb[2] = 1'b0;
    wcyc(8);
    `CHK("cap3_fall", 16'h0555, cap[2])
    pulse_stb(1);
    wcyc(84);
    pulse_stb(1);
    `CHK("timer1", 1'b1, (t1ms >= 16'h0009 && t1ms <= 16'h000B))
    $display("test strobe done");
  endtask
  task automatic test_quad();
    cfg.quad_mode = 1'b1;
    cfg.home_value = 16'h0321;
    cfg.preload_value = 16'h0777;
    tload_val = 32'h0000_0100;
    tload = 1'b1;
    wcyc(1);
    tload = 1'b0;
    {qa, qb} = 2'b10; wcyc(5); {qa, qb} = 2'b11; wcyc(5);
    {qa, qb} = 2'b01; wcyc(5); {qa, qb} = 2'b00; wcyc(8);
    `CHK("quad_steps", 1'b1, (tot === 32'h0000_0104 || tot === 32'h0000_00FC))
    host_word = 32'h0100_0000;
    wcyc(4);
    marker = 1'b1;
    wcyc(10);
    `CHK("home_found", 1'b1, home_found)
    `CHK("home_pos", 16'h0321, binv)
    `CHK("home_total", 32'h0000_0000, tot)
    pswitch = 1'b1;
    wcyc(10);
    `CHK("pl_latch", 1'b1, pl_latch)
    `CHK("pl_pos", 16'h0777, binv)
    `CHK("pl_total", 32'h0000_0000, tot)
    pswitch = 1'b0;
    cfg.preload_value = 16'h0888;
    wcyc(6);
    pswitch = 1'b1;
    wcyc(10);
    `CHK("pl_refused", 16'h0777, binv)
    pswitch = 1'b0;
    host_word = 32'h0200_0000;
    wcyc(6);
    `CHK("pl_clr", 1'b0, pl_latch)
    pswitch = 1'b1;
    wcyc(10);
    `CHK("pl_held", 16'h0888, binv)
    pswitch = 1'b0;
    cfg.preload_value = 16'h0999;
    host_word = 32'h0400_0000;
    wcyc(6);
    `CHK("pl_cmd", 16'h0999, binv)
    `CHK("pl_cmd_latch", 1'b0, pl_latch)
    host_word = 32'h0000_0000;
    marker = 1'b0;
    $display("test quad done");
  endtask
  task automatic pulse_err(input logic [15:0] c);
    err_code = c;
    err_ev = 1'b1;
    wcyc(1);
    err_ev = 1'b0;
    wcyc(3);
  endtask
  task automatic test_error();
    pulse_err(16'h00AB);
    `CHK("err_flag", 1'b1, err_flag)
    `CHK("err_word", 16'h00AB, err_st)
    host_word = 32'h8000_0000;
    wcyc(4);
    `CHK("err_clr", 1'b0, err_flag)
    `CHK("err_word_clr", 16'h0000, err_st)
    pulse_err(16'h00CD);
    `CHK("err_rearm", 16'h00CD, err_st)
    host_word = 32'h0000_0000;
    wcyc(3);
    host_word = 32'h8000_0000;
    wcyc(4);
    `CHK("err_clr2", 1'b0, err_flag)
    host_word = 32'h0000_0000;
    $display("test error done");
  endtask
  task automatic test_timer2();
    cfg.strobe_rising = 4'b1111;
    cfg.strobe_gated = 4'b0110;
    cfg.t2_two_input = 1'b1;
    host_word = 32'h0020_0000;
    pulse_stb(1);
    host_word = 32'h0000_0000;
    pwr = '{we: 1'b1, index: 5'd6, on_preset: 16'h1000, off_preset: 16'h2000};
    wcyc(1);
    pwr = '0;
    pulse_stb(3);
    pulse_stb(2);
    `CHK("timer2_gated", 16'h0000, t2ms)
    pwr = '{we: 1'b1, index: 5'd6, on_preset: 16'h0900, off_preset: 16'h0A00};
    wcyc(1);
    pwr = '0;
    pulse_stb(2);
    `CHK("timer2", 1'b1, (t2ms >= 16'h0002 && t2ms <= 16'h0004))
    $display("test timer2 done");
  endtask
  initial begin
    wcyc(10);
    RESETN = 1'b1;
    wcyc(2);
    test_abs_total();
    test_outputs();
    test_strobe();
    test_quad();
    test_error();
    test_timer2();
    finish_test();
  end
endmodule // tb_encoder_counter_io_control
`default_nettype wire
